// ---- verilog/adcs_sequencer.sv ----
`timescale 1ns/10ps
`include "adcs_cfg.svh"

// Summary of operation
// R1: two selectable input channels, each converted to an 8-bit unsigned code.
// R2: channel-zero select makes input zero the source until changed.
// R3: channel-one select makes input one the source until changed.
// R4: sampling window opens 0.20 cycle before strobe fall, closes 0.10 after.
// R5: address-latch strobe pulses high once per instruction cycle.
// R6: select and read instructions leave processor status flags untouched.
// R7: active-high reset gives a defined state; execution starts at address zero.
// R8: read copies the result register to the accumulator; one byte, two cycles.
// R9: each select is one byte and finishes in one instruction cycle.
// R10: convert continuously; result register holds the latest finished value.
module adcs_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cpu_reset,
  // converter commands from the core, one-cycle pulses
  input wire logic select_channel_zero_cmd,
  input wire logic select_channel_one_cmd,
  input wire logic read_conversion_result_cmd,
  // digitised analogue inputs
  input wire logic [7:0] analog_input_zero,
  input wire logic [7:0] analog_input_one,
  // answers to the core
  output logic [7:0] acc_data,
  output logic acc_load,
  output logic instr_done,
  // converter status
  output logic [7:0] conversion_result_reg,
  output logic channel_one_selected,
  output logic flags_write,
  // timing
  output logic address_latch_strobe,
  output logic sample_window,
  // program restart after a core reset
  output logic [11:0] start_pc,
  output logic start_pc_load
);

  adcs_pkg::adcs_state_s_t s_reg;
  adcs_pkg::adcs_state_s_t s_next;

  // last phase of an instruction cycle; the counter wraps on the next edge
  function automatic logic adcs_cycle_end(input logic [8:0] ph);
    adcs_cycle_end = (ph == `ADCS_PHASE_LAST);
  endfunction

  // shared arithmetic: wrap the phase counter at the instruction cycle end
  function automatic logic [8:0] adcs_phase_step(input logic [8:0] ph);
    adcs_phase_step = adcs_cycle_end(ph) ? 9'h000 : 9'(ph + 9'h001);
  endfunction

  // strobe level for a phase: high in the first half only
  function automatic logic adcs_strobe_level(input logic [8:0] ph);
    adcs_strobe_level = (ph < `ADCS_STROBE_FALL);
  endfunction

  // sample window around the strobe fall; open end inclusive, close end exclusive
  function automatic logic adcs_in_window(input logic [8:0] ph);
    adcs_in_window = (ph >= `ADCS_WIN_OPEN) && (ph < `ADCS_WIN_CLOSE);
  endfunction

  // source for the latched selection; anything but input one reads input zero
  function automatic logic [7:0] adcs_pick_source(
    input adcs_pkg::adcs_chan_t ch,
    input logic [7:0] in_zero,
    input logic [7:0] in_one
  );
    adcs_pick_source = (ch == adcs_pkg::ADCS_CH_ONE) ? in_one : in_zero;
  endfunction

  // last instruction cycle of a conversion span
  function automatic logic adcs_conv_last(input logic [2:0] cnt);
    adcs_conv_last = (cnt == 3'(`ADCS_CONV_CYCLES - 3'h1));
  endfunction

  // conversion span counter: counts instruction cycles, wraps after the last one
  function automatic logic [2:0] adcs_conv_step(input logic [2:0] cnt);
    adcs_conv_step = adcs_conv_last(cnt) ? 3'h0 : 3'(cnt + 3'h1);
  endfunction

  // cycle ends still owed by an instruction, one less than its length
  function automatic logic [1:0] adcs_count_down(input logic [1:0] cnt);
    adcs_count_down = 2'(cnt - 2'h1);
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic cycle_end;
    logic [7:0] src;
    // locals get a value first so no latch is inferred
    cycle_end = 1'b0;
    src = 8'h00;
    // one-cycle pulses drop unless set below
    s_next = s_reg;
    s_next.acc_load = 1'b0;
    s_next.instr_done = 1'b0;
    s_next.start_pc = 1'b0;
    // phase counter runs freely; no instruction stalls it
    cycle_end = adcs_cycle_end(s_reg.phase);
    s_next.phase = adcs_phase_step(s_reg.phase);

    // strobe high in the first half, one falling edge per cycle
    s_next.strobe = adcs_strobe_level(s_next.phase); // R5
    // taken from the next phase so the registered window lines up with the phase
    s_next.window = adcs_in_window(s_next.phase); // R4

    // pick the source per the latched selection
    src = adcs_pick_source(s_reg.chan, analog_input_zero, analog_input_one); // R1
    // track the input through the window, hold the last value at close
    // a source that moves after the close is not seen until the next span
    if (s_reg.window && !s_reg.sampled) begin
      s_next.sample = src; // R4
    end
    if (s_reg.window && !s_next.window) begin
      s_next.sampled = 1'b1;
    end

    // conversion spans four instruction cycles, then restarts
    // only the first window of a span is taken, so a result can lag by one span
    if (cycle_end) begin
      if (adcs_conv_last(s_reg.conv_cnt)) begin
        s_next.result = s_reg.sample; // R10
        s_next.sampled = 1'b0;
      end
      s_next.conv_cnt = adcs_conv_step(s_reg.conv_cnt);
    end

    // instruction handling; selection persists until the next select or a core reset
    case (s_reg.state)
      adcs_pkg::ADCS_ST_IDLE: begin
        // zero wins over one, one over read, when pulses coincide
        if (select_channel_zero_cmd) begin
          s_next.chan = adcs_pkg::ADCS_CH_ZERO; // R2
          s_next.busy_cnt = adcs_count_down(`ADCS_SELECT_CYCLES);
          s_next.state = adcs_pkg::ADCS_ST_DONE; // R9
        end else if (select_channel_one_cmd) begin
          s_next.chan = adcs_pkg::ADCS_CH_ONE; // R3
          s_next.busy_cnt = adcs_count_down(`ADCS_SELECT_CYCLES);
          s_next.state = adcs_pkg::ADCS_ST_DONE; // R9
        end else if (read_conversion_result_cmd) begin
          s_next.busy_cnt = adcs_count_down(`ADCS_READ_CYCLES);
          s_next.state = adcs_pkg::ADCS_ST_READ; // R8
        end
      end

      adcs_pkg::ADCS_ST_READ: begin
        // first cycle end closes the taking cycle, the second delivers the result
        // commands arriving meanwhile are dropped; the core never overlaps them
        if (cycle_end) begin
          if (s_reg.busy_cnt == 2'h0) begin
            // freshest value, even when a conversion finishes on this very edge
            s_next.acc_data = s_next.result; // R8
            s_next.acc_load = 1'b1;
            s_next.state = adcs_pkg::ADCS_ST_DONE;
          end else begin
            s_next.busy_cnt = adcs_count_down(s_reg.busy_cnt);
          end
        end
      end

      adcs_pkg::ADCS_ST_DONE: begin
        // one-cycle completion pulse, then ready for the next command
        s_next.instr_done = 1'b1;
        s_next.state = adcs_pkg::ADCS_ST_IDLE;
      end

      default: begin
        // unused code: fall back to idle rather than hang
        s_next.state = adcs_pkg::ADCS_ST_IDLE;
      end
    endcase

    // status mirror of the selection, registered with it
    s_next.chan_one = (s_next.chan == adcs_pkg::ADCS_CH_ONE);

    // core reset: defined state, program restarts at zero
    // result and conversion timing run on, so a restart loses no sample
    if (cpu_reset) begin
      s_next.state = adcs_pkg::ADCS_ST_IDLE; // R7
      s_next.chan = adcs_pkg::ADCS_CH_ZERO;
      s_next.chan_one = 1'b0;
      s_next.busy_cnt = 2'h0;
      s_next.acc_load = 1'b0;
      s_next.instr_done = 1'b0;
      s_next.pc_start = `ADCS_PC_RESET; // R7
      s_next.start_pc = 1'b1;
    end
  end

  // state register
  // reset leaves the strobe high, matching phase zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.state <= adcs_pkg::ADCS_ST_IDLE;
      s_reg.chan <= adcs_pkg::ADCS_CH_ZERO;
      s_reg.result <= `ADCS_RESULT_RESET;
      s_reg.strobe <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // read answer, straight from the state register
  assign acc_data = s_reg.acc_data;
  assign acc_load = s_reg.acc_load;
  assign instr_done = s_reg.instr_done;

  // converter status
  assign conversion_result_reg = s_reg.result;
  assign channel_one_selected = s_reg.chan_one;
  // none of these instructions touches a status flag, so the write never fires
  assign flags_write = 1'b0; // R6

  // timing reference, usable as a clock by the rest of the chip
  assign address_latch_strobe = s_reg.strobe;
  assign sample_window = s_reg.window;

  // restart address after a core reset
  assign start_pc = s_reg.pc_start;
  assign start_pc_load = s_reg.start_pc;

endmodule

// ---- verilog/adcs_cfg.svh ----
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// clock and instruction cycle timing
`define ADCS_CLK_PERIOD_NS 25
`define ADCS_INSTR_CYCLE_NS 8380
// cycles per instruction cycle: longest time, rounded down
`define ADCS_CYC_PER_INSTR ((`ADCS_INSTR_CYCLE_NS) / (`ADCS_CLK_PERIOD_NS))
`define ADCS_PHASE_W 9
`define ADCS_PHASE_LAST (9'((`ADCS_CYC_PER_INSTR) - 1))
// strobe high for the first half of the instruction cycle, falls at the midpoint
`define ADCS_STROBE_FALL (9'((`ADCS_CYC_PER_INSTR) / 2))
// sample window: setup 0.20 and hold 0.10 of an instruction cycle, in hundredths
`define ADCS_SETUP_HUNDREDTHS 20
`define ADCS_HOLD_HUNDREDTHS 10
`define ADCS_SETUP_CYC (9'(((`ADCS_CYC_PER_INSTR) * (`ADCS_SETUP_HUNDREDTHS)) / 100))
`define ADCS_HOLD_CYC (9'(((`ADCS_CYC_PER_INSTR) * (`ADCS_HOLD_HUNDREDTHS)) / 100))
`define ADCS_WIN_OPEN (9'((`ADCS_STROBE_FALL) - (`ADCS_SETUP_CYC)))
`define ADCS_WIN_CLOSE (9'((`ADCS_STROBE_FALL) + (`ADCS_HOLD_CYC)))
// conversion takes four instruction cycles
`define ADCS_CONV_CYCLES 3'h4
// instruction lengths in instruction cycles
`define ADCS_SELECT_CYCLES 2'h1
`define ADCS_READ_CYCLES 2'h2
// data widths and reset values
`define ADCS_DATA_W 8
`define ADCS_RESULT_RESET 8'h00
`define ADCS_PC_W 12
`define ADCS_PC_RESET 12'h000

`endif

// ---- verilog/adcs_pkg.sv ----
package adcs_pkg;

  // converter input selection
  typedef enum logic [1:0] {
    ADCS_CH_ZERO = 2'b01,
    ADCS_CH_ONE = 2'b10
  } adcs_chan_t;

  // instruction sequencing state
  typedef enum logic [2:0] {
    ADCS_ST_IDLE = 3'b001,
    ADCS_ST_READ = 3'b010,
    ADCS_ST_DONE = 3'b100
  } adcs_state_t;

  typedef struct packed {
    adcs_state_t state;
    adcs_chan_t chan;
    logic [8:0] phase;
    logic [2:0] conv_cnt;
    logic [7:0] sample;
    logic sampled;
    logic [7:0] result;
    logic [7:0] acc_data;
    logic acc_load;
    logic instr_done;
    logic [1:0] busy_cnt;
    logic strobe;
    logic window;
    logic [11:0] pc_start;
    logic start_pc;
    logic chan_one;
  } adcs_state_s_t;

endpackage

// ---- sim/adcs_sequencer_asserts.sv ----
`timescale 1ns/10ps
module adcs_sequencer_asserts (
  // clock and reset
  input wire logic clk, input wire logic rst_b, input wire logic cpu_reset,
  // commands and inputs
  input wire logic select_channel_zero_cmd, input wire logic select_channel_one_cmd,
  input wire logic read_conversion_result_cmd,
  input wire logic [7:0] analog_input_zero, input wire logic [7:0] analog_input_one,
  // answers and timing
  input wire logic [7:0] acc_data, input wire logic acc_load, input wire logic instr_done,
  input wire logic [7:0] conversion_result_reg, input wire logic channel_one_selected,
  input wire logic flags_write, input wire logic address_latch_strobe, input wire logic sample_window,
  input wire logic [11:0] start_pc, input wire logic start_pc_load
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [8:0] gap;
  logic prev;
  logic seen;
  // cycles since last strobe rise; seen skips the partial first period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 9'h000;
      prev <= 1'b1;
      seen <= 1'b0;
    end else begin
      prev <= address_latch_strobe;
      gap <= (address_latch_strobe && !prev) ? 9'h000 : gap + 9'h001;
      seen <= seen | (address_latch_strobe && !prev);
    end
  end
  chk_flags_quiet: assert property (flags_write == 1'b0) else $error("flags written");
  chk_strobe_period: assert property (seen && address_latch_strobe && !prev |-> gap == 9'h14e)
    else $error("strobe period wrong");
  chk_strobe_high: assert property (seen && !address_latch_strobe && prev |-> gap == 9'h0a6)
    else $error("strobe high time wrong");
  chk_window_span: assert property ($fell(address_latch_strobe) |-> sample_window && $past(sample_window, 67) &&
    !$past(sample_window, 68) ##32 sample_window ##1 !sample_window) else $error("window misplaced");
  chk_sel_one_done: assert property ($rose(channel_one_selected) |=> instr_done)
    else $error("select not done");
  chk_chan_cause: assert property ($changed(channel_one_selected) |-> $past(select_channel_zero_cmd) ||
    $past(select_channel_one_cmd) || $past(cpu_reset) || $past(cpu_reset, 2)) else $error("channel moved");
  chk_load_done: assert property (acc_load |=> instr_done) else $error("read not done");
  chk_read_latest: assert property (acc_load |-> acc_data == conversion_result_reg) else $error("read stale");
  chk_done_pulse: assert property (instr_done |=> !instr_done) else $error("done too long");
  chk_pc_zero: assert property (start_pc_load |-> start_pc == 12'h000) else $error("start not zero");
  chk_pc_load: assert property (cpu_reset |=> start_pc_load) else $error("no start load");
  cov_read: cover property (acc_load);
  cov_sel: cover property ($rose(channel_one_selected));
  cov_rst: cover property (start_pc_load);
endmodule

// ---- sim/adcs_core_model.sv ----
`timescale 1ns/10ps
// core side: one command pulse, then a bounded wait for its end
module adcs_core_model (
  // clock
  input wire logic clk,
  // commands
  output logic sel0, output logic sel1, output logic rd,
  // answers
  input wire logic done, input wire logic load, input wire logic [7:0] data
);
  logic [7:0] got;
  int lat;
  initial {rd, sel1, sel0} = 3'b000;
  // bound keeps a lost answer from hanging the core
  task automatic issue(input logic [2:0] k);
    @(posedge clk);
    {rd, sel1, sel0} <= k;
    @(posedge clk);
    {rd, sel1, sel0} <= 3'b000;
    lat = 0;
    got = 8'h00;
    while (done !== 1'b1 && lat < 800) begin
      @(posedge clk);
      #1;
      lat++;
      if (load === 1'b1) got = data;
    end
  endtask
endmodule

// ---- sim/adcs_sequencer_tb.sv ----
`timescale 1ns/10ps
module adcs_sequencer_tb;
  logic clk, rst_b, cpu_reset, sel0, sel1, rd, load, done, ch1, flg, stb, win, pcl, seen;
  logic [7:0] in0, in1, acc, res;
  logic [11:0] pc;
  int error_cnt, checked;
  adcs_sequencer dut_u (.clk(clk), .rst_b(rst_b), .cpu_reset(cpu_reset), .select_channel_zero_cmd(sel0),
    .select_channel_one_cmd(sel1), .read_conversion_result_cmd(rd), .analog_input_zero(in0),
    .analog_input_one(in1), .acc_data(acc), .acc_load(load), .instr_done(done), .conversion_result_reg(res),
    .channel_one_selected(ch1), .flags_write(flg), .address_latch_strobe(stb), .sample_window(win),
    .start_pc(pc), .start_pc_load(pcl));
  adcs_core_model core_u (.clk(clk), .sel0(sel0), .sel1(sel1), .rd(rd), .done(done), .load(load), .data(acc));
  // byte and flag compare
  task automatic cmpv(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // latency compare
  task automatic cmpr(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("[ERR] %0t latency %0d", $time, g);
    end
  endtask
  task automatic t_reset;
    #1;
    cmpv(res, 12'h000);
    cmpv(ch1, 12'h000);
    $display("reset test done");
  endtask
  // convert on one channel, then the other; read waits nine instruction cycles, over two full conversions
  task automatic t_conv;
    core_u.issue(3'b010);
    cmpv(ch1, 12'h001);
    cmpr(core_u.lat, 1, 1);
    repeat (9 * 335) @(posedge clk);
    core_u.issue(3'b100);
    cmpv(core_u.got, 12'h0c3);
    cmpv(res, 12'h0c3);
    cmpr(core_u.lat, 336, 672);
    core_u.issue(3'b011);
    cmpv(ch1, 12'h000);
    repeat (9 * 335) @(posedge clk);
    core_u.issue(3'b100);
    cmpv(core_u.got, 12'h03c);
    cmpv(res, 12'h03c);
    cmpv(flg, 12'h000);
    $display("convert test done");
  endtask
  task automatic t_cpurst;
    core_u.issue(3'b010);
    cmpv(ch1, 12'h001);
    seen = 1'b0;
    @(posedge clk);
    cpu_reset <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      cpu_reset <= 1'b0;
      #1;
      if (pcl === 1'b1) seen = 1'b1;
    end
    cmpv(seen, 12'h001);
    cmpv(pc, 12'h000);
    cmpv(ch1, 12'h000);
    $display("core reset test done");
  endtask
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_b, cpu_reset} = 2'b00;
    in0 = 8'h3c;
    in1 = 8'hc3;
    error_cnt = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_conv;
    t_cpurst;
    results;
  end
  // nearly three times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog", $time);
    results;
  end
endmodule
bind adcs_sequencer adcs_sequencer_asserts chk_u (.clk, .rst_b, .cpu_reset, .select_channel_zero_cmd,
  .select_channel_one_cmd, .read_conversion_result_cmd, .analog_input_zero, .analog_input_one, .acc_data,
  .acc_load, .instr_done, .conversion_result_reg, .channel_one_selected, .flags_write, .address_latch_strobe,
  .sample_window, .start_pc, .start_pc_load);
